// ---- logic/urx_consts.svh ----
// Register offsets, field positions, reset values and sampling figures of the receiver.
// Assumes inclusion by bare name from logic/ and sim/ files.
`ifndef URX_CONSTS_SVH
`define URX_CONSTS_SVH

// Byte offsets on the APB register bus.
`define URX_OFS_CTRL      8'h00
`define URX_OFS_BAUD      8'h04
`define URX_OFS_STATUS    8'h08
`define URX_OFS_DATA      8'h0C

// Control register fields.
`define URX_CTRL_EN       0
`define URX_CTRL_U2X      1
`define URX_CTRL_PODD     2
`define URX_CTRL_PEN      3
`define URX_CTRL_SIZE_LO  4
`define URX_CTRL_SIZE_HI  5
`define URX_CTRL_RST      6'h00

// Status register fields.
`define URX_ST_RXC        0
`define URX_ST_FE         1
`define URX_ST_DOR        2
`define URX_ST_PE         3
`define URX_ST_BUSY       4

// Sample tick divisor, a tick every divisor plus one clocks.
`define URX_BAUD_W        12
`define URX_BAUD_RST      12'h03F

// Samples per bit and centre voting samples.
`define URX_SPB_NORM      5'h10
`define URX_SPB_DBL       5'h08
`define URX_V1_NORM       5'h08
`define URX_V1_DBL        5'h04
// Double speed must not look for a new start before this stop sample.
`define URX_STOP_END_DBL  5'h07

// Frame entry layout in the receive buffer.
`define URX_ENT_FE        8
`define URX_ENT_PE        9
`define URX_ENT_DOR       10
`define URX_DATA_MIN      4'h5

`endif

// ---- logic/urx_pkg.sv ----
// Types shared by the receiver and its receive buffer.
// Assumes the constants header sits beside it.
`default_nettype none

package urx_pkg;
	// Receiver sequencer phases.
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} urx_state_t;
	// One buffered frame: overrun, parity error, frame error and eight data bits.
	typedef logic [10:0] urx_entry_t;
endpackage

`default_nettype wire

// ---- logic/urx_fifo.sv ----
// Two-frame receive buffer with flush; the head entry comes straight out of a register.
// Assumes push is only offered while not full unless a pop happens in the same cycle.
`include "urx_consts.svh"
`default_nettype none

module urx_fifo (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              flush,
	input  wire logic              push,
	input  wire urx_pkg::urx_entry_t push_data,
	input  wire logic              pop,
	output urx_pkg::urx_entry_t    head,
	output logic                   not_empty,
	output logic                   full
);
	urx_pkg::urx_entry_t e0_r, e0_nxt, e1_r, e1_nxt;
	logic [1:0]          cnt_r, cnt_nxt;
	logic                pv, sv;
	logic [1:0]          wpos;

	// Pop shifts the second entry forward; the push lands behind what is left.
	always_comb
	begin
		pv      = pop && (cnt_r != 2'h0);
		sv      = push && ((cnt_r != 2'h2) || pv);
		e0_nxt  = e0_r;
		e1_nxt  = e1_r;
		wpos    = cnt_r - {1'b0, pv};
		if (pv)
		begin
			e0_nxt = e1_r;
		end
		if (sv)
		begin
			if (wpos == 2'h0)
				e0_nxt = push_data;
			else
				e1_nxt = push_data;
		end
		cnt_nxt = cnt_r - {1'b0, pv} + {1'b0, sv};
		if (flush)
		begin
			cnt_nxt = 2'h0;
		end
	end

	// Buffer storage.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			e0_r  <= 11'h000;
			e1_r  <= 11'h000;
			cnt_r <= 2'h0;
		end
		else
		begin
			e0_r  <= e0_nxt;
			e1_r  <= e1_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign head      = e0_r;
	assign not_empty = (cnt_r != 2'h0);
	assign full      = (cnt_r == 2'h2);
endmodule

`default_nettype wire

// ---- logic/urx_receiver.sv ----
// Asynchronous serial receiver: start detection, three-sample voting, parity and frame checks,
// a two-frame receive buffer and an APB register slave.
// Assumes APB signals synchronous to mclk; the serial pin is asynchronous and is synchronised here.
//
// Notes on behaviour
// - Parity checked only when parity enable set.
// - Odd-select bit picks odd or even parity.
// - Parity result stored with frame in buffer.
// - Parity flag follows oldest frame, zero if off.
// - Disable aborts any frame in progress immediately.
// - Disable releases pin and flushes buffer.
// - Sixteen samples per bit, eight in double.
// - Falling edge starts detection, first low sample one.
// - Start voted on 8-10 or 4-6; majority high rejects.
// - Reject returns to idle; valid start resynchronises.
// - Per-bit sample counter of sixteen or eight states.
// - Each bit decided by three-sample majority.
// - Recover data and parity through first stop.
// - Only the first stop bit is examined.
// - Low first stop bit sets frame error.
// - Normal speed rearms after last vote; double later.
// - Data plus parity spans five to nine bits.
// - Receive-complete high exactly while buffer holds frames.
// - Two-frame buffer; overrun on full, waiting, new start.
`include "urx_consts.svh"
`default_nettype none

module urx_receiver (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_receive_pin,
	output logic             rx_pin_claimed
);
	// Three-sample majority, used for the start bit and every later bit.
	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	// Configuration registers.
	logic [5:0]             ctrl_r, ctrl_nxt;
	logic [`URX_BAUD_W-1:0] baud_div_r, baud_div_nxt;
	logic                   receiver_enable, double_speed_select, parity_odd_select, parity_enable_bit;

	assign receiver_enable     = ctrl_r[`URX_CTRL_EN];
	assign double_speed_select = ctrl_r[`URX_CTRL_U2X];
	assign parity_odd_select   = ctrl_r[`URX_CTRL_PODD];
	assign parity_enable_bit   = ctrl_r[`URX_CTRL_PEN];
	assign rx_pin_claimed      = receiver_enable;

	// Pin synchroniser; only the second stage is looked at.
	logic sync1_r, sync2_r;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end
		else
		begin
			sync1_r <= serial_receive_pin;
			sync2_r <= sync1_r;
		end
	end

	// Sample tick divider; it holds in reload while the receiver is off so the first tick is predictable.
	logic [`URX_BAUD_W-1:0] baud_cnt_r, baud_cnt_nxt;
	logic                   tick;

	always_comb
	begin
		tick         = receiver_enable && (baud_cnt_r == '0);
		baud_cnt_nxt = baud_cnt_r - 1'b1;
		if (!receiver_enable || tick)
			baud_cnt_nxt = baud_div_r;
	end

	// Sampling geometry for the chosen speed.
	logic [4:0] spb, v1, v2, v3, stop_end;
	logic [3:0] n_data, n_total;

	always_comb
	begin
		spb      = double_speed_select ? `URX_SPB_DBL : `URX_SPB_NORM;
		v1       = double_speed_select ? `URX_V1_DBL : `URX_V1_NORM;
		v2       = v1 + 5'h01;
		v3       = v1 + 5'h02;
		stop_end = double_speed_select ? `URX_STOP_END_DBL : v3;
		n_data   = `URX_DATA_MIN + {2'b00, ctrl_r[`URX_CTRL_SIZE_HI:`URX_CTRL_SIZE_LO]};
		n_total  = n_data + {3'b000, parity_enable_bit};
	end

	// Receiver sequencer state.
	urx_pkg::urx_state_t state_r, state_nxt;
	logic [4:0]          samp_r, samp_nxt;
	logic [3:0]          bitcnt_r, bitcnt_nxt;
	logic [1:0]          vs_r, vs_nxt;
	logic [7:0]          data_r, data_nxt;
	logic                pbit_r, pbit_nxt;
	logic                prev_r, prev_nxt;
	logic                hold_v_r, hold_v_nxt;
	urx_pkg::urx_entry_t hold_r, hold_nxt;
	logic                dor_pend_r, dor_pend_nxt;
	logic                vote, push;
	logic                fifo_full, fifo_ne;
	urx_pkg::urx_entry_t head;
	logic [7:0]          data_kept;

	// Bits beyond the frame's length still hold an earlier frame's leftovers, so they are masked before use.
	assign data_kept = data_r & (8'hFF >> (4'h8 - n_data));

	// The finished frame waits in a holding register, separate from the data register, until the buffer has room.
	always_comb
	begin
		state_nxt    = state_r;
		samp_nxt     = samp_r;
		bitcnt_nxt   = bitcnt_r;
		vs_nxt       = vs_r;
		data_nxt     = data_r;
		pbit_nxt     = pbit_r;
		prev_nxt     = prev_r;
		hold_nxt     = hold_r;
		dor_pend_nxt = dor_pend_r;
		vote         = maj3(vs_r[0], vs_r[1], sync2_r);
		push         = hold_v_r && !fifo_full;
		hold_v_nxt   = hold_v_r && !push;
		if (!receiver_enable)
		begin
			state_nxt    = urx_pkg::ST_IDLE;
			hold_v_nxt   = 1'b0;
			dor_pend_nxt = 1'b0;
			prev_nxt     = 1'b0;
		end
		else if (tick)
		begin
			prev_nxt = sync2_r;
			samp_nxt = (samp_r == spb) ? 5'h01 : samp_r + 5'h01;
			if (samp_r == v1)
				vs_nxt[0] = sync2_r;
			if (samp_r == v2)
				vs_nxt[1] = sync2_r;
			unique case (state_r)
				urx_pkg::ST_IDLE:
				begin
					if (prev_r && !sync2_r)
					begin
						state_nxt = urx_pkg::ST_START;
						samp_nxt  = 5'h02;
						if (hold_v_r && fifo_full)
							dor_pend_nxt = 1'b1;
					end
				end
				urx_pkg::ST_START:
				begin
					if (samp_r == v3 && vote)
						state_nxt = urx_pkg::ST_IDLE;
					else if (samp_r == spb)
					begin
						state_nxt  = urx_pkg::ST_BITS;
						bitcnt_nxt = 4'h0;
					end
				end
				urx_pkg::ST_BITS:
				begin
					if (samp_r == v3)
					begin
						if (bitcnt_r < n_data)
							data_nxt[bitcnt_r[2:0]] = vote;
						else
							pbit_nxt = vote;
					end
					if (samp_r == spb)
					begin
						bitcnt_nxt = bitcnt_r + 4'h1;
						if (bitcnt_r == n_total - 4'h1)
							state_nxt = urx_pkg::ST_STOP;
					end
				end
				urx_pkg::ST_STOP:
				begin
					if (samp_r == v3)
					begin
						// Only this stop bit is voted; any second one is treated as idle line.
						hold_nxt                = {3'b000, data_kept};
						hold_nxt[`URX_ENT_FE]   = !vote;
						hold_nxt[`URX_ENT_PE]   = parity_enable_bit && (^data_kept ^ parity_odd_select ^ pbit_r);
						hold_nxt[`URX_ENT_DOR]  = dor_pend_r;
						hold_v_nxt              = 1'b1;
						dor_pend_nxt            = 1'b0;
					end
					if (samp_r == stop_end)
						state_nxt = urx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_r    <= urx_pkg::ST_IDLE;
			samp_r     <= 5'h01;
			bitcnt_r   <= 4'h0;
			vs_r       <= 2'h0;
			data_r     <= 8'h00;
			pbit_r     <= 1'b0;
			prev_r     <= 1'b0;
			hold_v_r   <= 1'b0;
			hold_r     <= 11'h000;
			dor_pend_r <= 1'b0;
			baud_cnt_r <= `URX_BAUD_RST;
		end
		else
		begin
			state_r    <= state_nxt;
			samp_r     <= samp_nxt;
			bitcnt_r   <= bitcnt_nxt;
			vs_r       <= vs_nxt;
			data_r     <= data_nxt;
			pbit_r     <= pbit_nxt;
			prev_r     <= prev_nxt;
			hold_v_r   <= hold_v_nxt;
			hold_r     <= hold_nxt;
			dor_pend_r <= dor_pend_nxt;
			baud_cnt_r <= baud_cnt_nxt;
		end
	end

	// APB decode; the slave answers in the first access cycle, so there are no wait states.
	logic        setup, access, pop;
	logic        hit_ctrl, hit_baud, hit_stat, hit_data, mapped;
	logic [31:0] rdata, prdata_r, prdata_nxt;

	always_comb
	begin
		setup    = psel && !penable;
		access   = psel && penable;
		hit_ctrl = (paddr == `URX_OFS_CTRL);
		hit_baud = (paddr == `URX_OFS_BAUD);
		hit_stat = (paddr == `URX_OFS_STATUS);
		hit_data = (paddr == `URX_OFS_DATA);
		mapped   = hit_ctrl || hit_baud || hit_stat || hit_data;
		pop      = access && !pwrite && hit_data;
		rdata    = 32'h0000_0000;
		if (hit_ctrl)
			rdata[5:0] = ctrl_r;
		if (hit_baud)
			rdata[`URX_BAUD_W-1:0] = baud_div_r;
		if (hit_stat)
		begin
			rdata[`URX_ST_RXC]  = fifo_ne;
			rdata[`URX_ST_FE]   = fifo_ne && head[`URX_ENT_FE];
			rdata[`URX_ST_DOR]  = fifo_ne && head[`URX_ENT_DOR];
			rdata[`URX_ST_PE]   = fifo_ne && parity_enable_bit && head[`URX_ENT_PE];
			rdata[`URX_ST_BUSY] = (state_r != urx_pkg::ST_IDLE);
		end
		if (hit_data)
			rdata[7:0] = head[7:0]; // rx_data_register
		prdata_nxt = setup ? rdata : prdata_r;
	end

	// Register writes take effect at the access edge; status and data are read-only.
	always_comb
	begin
		ctrl_nxt     = ctrl_r;
		baud_div_nxt = baud_div_r;
		if (access && pwrite && hit_ctrl)
			ctrl_nxt = pwdata[5:0];
		if (access && pwrite && hit_baud)
			baud_div_nxt = pwdata[`URX_BAUD_W-1:0];
	end

	// Bus-facing registers.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_r     <= `URX_CTRL_RST;
			baud_div_r <= `URX_BAUD_RST;
			prdata_r   <= 32'h0000_0000;
		end
		else
		begin
			ctrl_r     <= ctrl_nxt;
			baud_div_r <= baud_div_nxt;
			prdata_r   <= prdata_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = access;
	assign pslverr = access && !mapped;

	// Receive buffer; disabling the receiver empties it.
	urx_fifo u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.flush     (!receiver_enable),
		.push      (push),
		.push_data (hold_r),
		.pop       (pop),
		.head      (head),
		.not_empty (fifo_ne),
		.full      (fifo_full)
	);
endmodule

`default_nettype wire

// ---- sim/urx_receiver_properties.sv ----
// Concurrent checks on the receiver's APB answers and on its claim of the serial pin.
// Assumes binding onto the receiver top module; it sees only that module's ports.
`include "urx_consts.svh"
`default_nettype none

module urx_receiver_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serial_receive_pin,
	input wire logic        rx_pin_claimed
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Decoded access cycles; a transfer completes at the edge that samples one.
	wire logic acc = psel && penable;
	wire logic rd_st = acc && !pwrite && paddr == `URX_OFS_STATUS;
	wire logic rd_dt = acc && !pwrite && paddr == `URX_OFS_DATA;
	wire logic wr_ct = acc && pwrite && paddr == `URX_OFS_CTRL;
	wire logic mapped = paddr inside {`URX_OFS_CTRL, `URX_OFS_BAUD, `URX_OFS_STATUS, `URX_OFS_DATA};

	// Status read once the flush has had two cycles to land.
	sequence s_off;
		!rx_pin_claimed [*2];
	endsequence
	sequence s_off_rd;
		s_off ##1 (rd_st && !rx_pin_claimed);
	endsequence

	property p_ready;
		pready == acc;
	endproperty
	property p_slverr;
		pslverr == (acc && !mapped);
	endproperty
	property p_err_zero;
		pslverr && !pwrite |-> prdata == 32'h0000_0000;
	endproperty
	property p_rd_hold;
		acc ##1 !psel |-> $stable(prdata);
	endproperty
	property p_claim;
		wr_ct |=> rx_pin_claimed == $past(pwdata[`URX_CTRL_EN]);
	endproperty
	property p_claim_hold;
		!wr_ct |=> $stable(rx_pin_claimed);
	endproperty
	property p_rst_claim;
		$fell(rst) |-> !rx_pin_claimed;
	endproperty
	property p_off_empty;
		s_off_rd |-> prdata[`URX_ST_RXC] == 1'b0 && prdata[`URX_ST_BUSY] == 1'b0;
	endproperty
	property p_high_zero;
		(rd_st |-> prdata[31:5] == 27'h0000000) and (rd_dt |-> prdata[31:8] == 24'h000000);
	endproperty

	a_ready: assert property (p_ready) else $error("pready differs from psel and penable");
	a_slverr: assert property (p_slverr) else $error("pslverr differs from the address decode");
	a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved after the access");
	a_claim: assert property (p_claim) else $error("pin claim does not follow the enable write");
	a_claim_hold: assert property (p_claim_hold) else $error("pin claim changed without a write");
	a_rst_claim: assert property (p_rst_claim) else $error("pin claimed right after reset");
	a_off_empty: assert property (p_off_empty) else $error("disabled receiver shows data");
	a_high_zero: assert property (p_high_zero) else $error("unused read bits are not zero");
endmodule

bind urx_receiver urx_receiver_checker u_chk (
	.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_receive_pin(serial_receive_pin), .rx_pin_claimed(rx_pin_claimed)
);

`default_nettype wire

// ---- sim/urx_tx_model.sv ----
// Behavioural remote transmitter that drives the serial line, idle high.
// Assumes the bench calls its tasks; every level change lands right after a rising clock edge.
`default_nettype none

module urx_tx_model (
	input  wire logic mclk,
	output logic      line
);
	timeunit 1ns;
	timeprecision 1ns;

	// The line idles high, so no edge is seen before the first frame.
	initial line = 1'b1;

	// Holds one level for a whole number of clocks.
	task automatic hold(input logic v, input int clks);
		@(posedge mclk);
		line <= v;
		repeat (clks - 1) @(posedge mclk);
	endtask

	// Start bit, then n bits LSB first; cyc equals the receiver's bit time, well inside its tolerance.
	task automatic send(input logic [9:0] bits, input int n, input int cyc);
		hold(1'b0, cyc);
		for (int i = 0; i < n; i++) hold(bits[i], cyc);
		@(posedge mclk);
		line <= 1'b1;
	endtask
endmodule

`default_nettype wire

// ---- sim/urx_receiver_tb.sv ----
// Self-checking bench: APB master tasks and one task per receive scenario.
// Assumes the transmitter model drives the serial pin; divisor 1 gives two clocks per sample.
`include "urx_consts.svh"
`default_nettype none

module urx_receiver_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rdv;
	logic        pready;
	logic        pslverr;
	logic        claimed;
	wire logic   rx_line;
	int          fail_count = 0;
	int          num_checks = 0;

	// 10 MHz clock.
	always #50 mclk = ~mclk;

	urx_receiver DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_receive_pin(rx_line), .rx_pin_claimed(claimed));
	urx_tx_model tx (.mclk(mclk), .line(rx_line));

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rdv);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0000_0000, rdv);
		chk(n, rdv, e);
	endtask

	// Builds a frame; the parity bit is placed so that flip alone makes it wrong.
	task automatic frm(input logic [7:0] d, input int nd, input logic pe, odd, flip, stop, input int cyc);
		logic [9:0] v;
		v = {2'b00, d & ((8'h01 << nd) - 8'h01)};
		v[nd] = ^v ^ odd ^ flip;
		v[nd + pe] = stop;
		tx.send(v, nd + pe + 1, cyc);
	endtask

	task automatic t_regs;
		rd(`URX_OFS_CTRL, 32'h0000_0000, "ctrl");
		rd(`URX_OFS_BAUD, 32'h0000_003F, "baud");
		rd(8'h10, 32'h0000_0000, "unmapped");
		wr(`URX_OFS_STATUS, 32'h0000_00FF);
		rd(`URX_OFS_STATUS, 32'h0000_0000, "status");
		wr(`URX_OFS_BAUD, 32'h0000_0001);
		$display("t_regs done");
	endtask

	// Eight low samples: sample 8 low, 9 and 10 high, so the start is rejected.
	task automatic t_spike;
		wr(`URX_OFS_CTRL, 32'h0000_0031);
		tx.hold(1'b0, 16);
		tx.hold(1'b1, 40);
		rd(`URX_OFS_STATUS, 32'h0000_0000, "spike");
		frm(8'hA5, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
		rd(`URX_OFS_STATUS, 32'h0000_0001, "st");
		rd(`URX_OFS_DATA, 32'h0000_00A5, "data");
		rd(`URX_OFS_STATUS, 32'h0000_0000, "drained");
		$display("t_spike done");
	endtask

	task automatic t_parity;
		for (int i = 0; i < 4; i++)
		begin
			wr(`URX_OFS_CTRL, 32'h0000_0039 | (i[0] << 2));
			frm(8'h6B, 8, 1'b1, i[0], i[1], 1'b1, 32);
			rd(`URX_OFS_STATUS, 32'h0000_0001 | (i[1] << 3), "pe");
			rd(`URX_OFS_DATA, 32'h0000_006B, "pdata");
		end
		$display("t_parity done");
	endtask

	task automatic t_misc;
		wr(`URX_OFS_CTRL, 32'h0000_0031);
		frm(8'h3C, 8, 1'b0, 1'b0, 1'b0, 1'b0, 32);
		rd(`URX_OFS_STATUS, 32'h0000_0003, "fe");
		rd(`URX_OFS_DATA, 32'h0000_003C, "fdata");
		wr(`URX_OFS_CTRL, 32'h0000_000B);
		frm(8'hF5, 5, 1'b1, 1'b0, 1'b0, 1'b1, 16);
		rd(`URX_OFS_STATUS, 32'h0000_0001, "dst");
		rd(`URX_OFS_DATA, 32'h0000_0015, "ddata");
		$display("t_misc done");
	endtask

	// Four frames back to back: the fourth replaces the waiting third and carries the loss.
	task automatic t_ovr;
		wr(`URX_OFS_CTRL, 32'h0000_0031);
		// The first stop bit is cut to twenty clocks, so the next start lands on the sample right after the vote.
		tx.send({2'b00, 8'h10}, 8, 32);
		tx.hold(1'b1, 19);
		for (int k = 1; k < 4; k++) frm(8'h10 + k, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
		rd(`URX_OFS_STATUS, 32'h0000_0001, "o1");
		rd(`URX_OFS_DATA, 32'h0000_0010, "od1");
		rd(`URX_OFS_STATUS, 32'h0000_0001, "o2");
		rd(`URX_OFS_DATA, 32'h0000_0011, "od2");
		rd(`URX_OFS_STATUS, 32'h0000_0005, "o3");
		rd(`URX_OFS_DATA, 32'h0000_0013, "od3");
		rd(`URX_OFS_STATUS, 32'h0000_0000, "o4");
		$display("t_ovr done");
	endtask

	task automatic t_off;
		frm(8'h77, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
		fork
			frm(8'h55, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
			begin
				repeat (100) @(posedge mclk);
				rd(`URX_OFS_STATUS, 32'h0000_0011, "busy");
				wr(`URX_OFS_CTRL, 32'h0000_0000);
				#10 chk("claim", {31'h0, claimed}, 32'h0000_0000);
				rd(`URX_OFS_STATUS, 32'h0000_0000, "flushed");
			end
		join
		wr(`URX_OFS_CTRL, 32'h0000_0031);
		frm(8'h99, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
		rd(`URX_OFS_STATUS, 32'h0000_0001, "rest");
		rd(`URX_OFS_DATA, 32'h0000_0099, "rdata");
		$display("t_off done");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence after two clocks of reset.
	initial
	begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_spike;
		t_parity;
		t_misc;
		t_ovr;
		t_off;
		wrap_up;
	end

	// Watchdog, about four times the expected run.
	initial
	begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		wrap_up;
	end
endmodule

`default_nettype wire
